// ==== core/tmc_in_sync.sv ====
`default_nettype none

module tmc_in_sync (
	input  wire logic   ref_clk_i,
	input  wire logic   nrst_i,
	input  wire logic   ext_event_i,
	input  wire logic   ext_trig_i,
	tmc_link_if.sync    lk
);

	logic [1:0] raw;
	logic [1:0] s1_r;
	logic [1:0] s1_nxt;
	logic [1:0] s2_r;
	logic [1:0] s2_nxt;
	logic [1:0] s3_r;
	logic [1:0] s3_nxt;

	assign raw = {ext_trig_i, ext_event_i};

	// The third stage only serves edge detection, so stage one feeds stage two alone.
	always_comb begin
		s1_nxt = raw;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s1_r <= 2'h0;
			s2_r <= 2'h0;
			s3_r <= 2'h0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
		end
	end

	assign lk.ev_edge    = s2_r[0] & ~s3_r[0];
	assign lk.trig_rise  = s2_r[1] & ~s3_r[1];
	assign lk.trig_fall  = ~s2_r[1] & s3_r[1];
	assign lk.trig_level = s2_r[1];

endmodule

`default_nettype wire

// ==== core/tmc_link_if.sv ====
`default_nettype none

interface tmc_link_if;
	logic ev_edge;
	logic trig_rise;
	logic trig_fall;
	logic trig_level;
	logic wave0;
	logic wave1;

	modport sync (output ev_edge, output trig_rise, output trig_fall, output trig_level);
	modport core (input ev_edge, input trig_rise, input trig_fall, input trig_level,
		output wave0, output wave1);
	modport pins (input wave0, input wave1);
endinterface

`default_nettype wire

// ==== core/tmc_out_stage.sv ====
`default_nettype none

module tmc_out_stage (
	input  wire logic       ref_clk_i,
	input  wire logic       nrst_i,
	input  wire logic [3:0] out_cfg_i,
	tmc_link_if.pins        lk,
	output logic            timer_out_pin0_o,
	output logic            timer_out_pin1_o
);

	logic [1:0] wave;
	logic [1:0] en;
	logic [1:0] lvl;
	logic [1:0] pin_r;
	logic [1:0] pin_nxt;

	assign wave = {lk.wave1, lk.wave0};
	assign en   = {out_cfg_i[tmc_pkg::OUT_EN1_BIT], out_cfg_i[tmc_pkg::OUT_EN0_BIT]};
	assign lvl  = {out_cfg_i[tmc_pkg::OUT_LVL1_BIT], out_cfg_i[tmc_pkg::OUT_LVL0_BIT]};

	for (genvar g = 0; g < 2; g++) begin : g_pin
		// Enabled pins carry the wave, inverted by the level bit; disabled pins
		// rest at the level bit itself.
		always_comb begin
			if (en[g]) begin
				pin_nxt[g] = wave[g] ^ lvl[g];
			end else begin
				pin_nxt[g] = lvl[g];
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_r <= 2'h0;
		end else begin
			pin_r <= pin_nxt;
		end
	end

	assign timer_out_pin0_o = pin_r[0];
	assign timer_out_pin1_o = pin_r[1];

endmodule

`default_nettype wire

// ==== core/tmc_pkg.sv ====
`default_nettype none

package tmc_pkg;

	// Register indices on the plain register port.
	localparam logic [3:0] ADDR_MODE    = 4'h0;
	localparam logic [3:0] ADDR_OUT     = 4'h1;
	localparam logic [3:0] ADDR_RUN     = 4'h2;
	localparam logic [3:0] ADDR_PER_LO  = 4'h3;
	localparam logic [3:0] ADDR_PER_HI  = 4'h4;
	localparam logic [3:0] ADDR_DUTY_LO = 4'h5;
	localparam logic [3:0] ADDR_DUTY_HI = 4'h6;
	localparam logic [3:0] ADDR_CNT_LO  = 4'h7;
	localparam logic [3:0] ADDR_CNT_HI  = 4'h8;
	localparam logic [3:0] ADDR_CAP_LO  = 4'h9;
	localparam logic [3:0] ADDR_CAP_HI  = 4'ha;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] ZERO_BYTE  = 8'h00;

	// Writable bits; everything else reads as zero.
	localparam logic [7:0] MODE_WMASK = 8'ha7;
	localparam logic [7:0] OUT_WMASK  = 8'h0f;
	localparam logic [7:0] RUN_WMASK  = 8'h87;

	localparam int MODE_SLAVE_BIT = 7;
	localparam int MODE_TRIG_BIT  = 6;
	localparam int MODE_EXT_BIT   = 5;
	localparam int OUT_LVL1_BIT   = 3;
	localparam int OUT_EN1_BIT    = 2;
	localparam int OUT_LVL0_BIT   = 1;
	localparam int OUT_EN0_BIT    = 0;
	localparam int RUN_BIT        = 7;

	localparam int PRE_W = 7;
	localparam logic [PRE_W-1:0] PRE_ONES = 7'h7f;
	localparam logic [PRE_W-1:0] PRE_ZERO = 7'h00;
	localparam logic [PRE_W-1:0] PRE_ONE  = 7'h01;

	typedef logic [15:0] tmc_cnt_t;
	localparam tmc_cnt_t CNT_ZERO = 16'h0000;
	localparam tmc_cnt_t CNT_ONE  = 16'h0001;
	localparam tmc_cnt_t CNT_MAX  = 16'hffff;

	// Declaration order gives the encodings 0 to 7 of the mode field.
	typedef enum logic [2:0] {
		MD_INTERVAL,
		MD_EVENT,
		MD_TRIG_PULSE,
		MD_ONE_SHOT,
		MD_PWM,
		MD_FREE_RUN,
		MD_WIDTH,
		MD_PROHIBITED
	} tmc_mode_e;

endpackage

`default_nettype wire

// ==== core/tmc_timer_channel.sv ====
`default_nettype none

module tmc_timer_channel (
	input  wire logic       ref_clk_i,
	input  wire logic       nrst_i,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic       bit_op_i,
	input  wire logic [2:0] bit_sel_i,
	output logic      [7:0] rdata_o,
	input  wire logic       ext_event_i,
	input  wire logic       ext_trig_i,
	input  wire logic       master_tick_i,
	input  wire logic       master_clear_i,
	output logic            count_tick_o,
	output logic            count_clear_o,
	output logic            timer_out_pin0_o,
	output logic            timer_out_pin1_o
);

	// A byte access replaces the whole register; a bit access touches one bit.
	function automatic logic [7:0] apply_write(input logic [7:0] old, input logic [7:0] wd,
		input logic bop, input logic [2:0] sel);
		logic [7:0] v;
		v = old;
		if (bop) begin
			v[sel] = wd[0];
		end else begin
			v = wd;
		end
		return v;
	endfunction

	tmc_link_if lk ();

	logic                 [7:0] mode_r;
	logic                 [7:0] mode_nxt;
	logic                 [7:0] out_r;
	logic                 [7:0] out_nxt;
	logic                 [7:0] run_r;
	logic                 [7:0] run_nxt;
	logic                 [7:0] cmp_r   [4];
	logic                 [7:0] cmp_nxt [4];
	logic                 [7:0] rdata_r;
	logic                 [7:0] rdata_nxt;
	logic                 [7:0] mode_wv;
	logic                 [7:0] rd_byte;
	logic                       soft_trig;
	tmc_pkg::tmc_mode_e         mode;
	tmc_pkg::tmc_cnt_t          period;
	tmc_pkg::tmc_cnt_t          duty;
	tmc_pkg::tmc_cnt_t          cnt_r;
	tmc_pkg::tmc_cnt_t          cnt_nxt;
	tmc_pkg::tmc_cnt_t          cap_r;
	tmc_pkg::tmc_cnt_t          cap_nxt;
	logic [tmc_pkg::PRE_W-1:0]  div_r;
	logic [tmc_pkg::PRE_W-1:0]  div_nxt;
	logic [tmc_pkg::PRE_W-1:0]  pre_mask;
	logic                       pre_tick;
	logic                       ext_src;
	logic                       slave;
	logic                       running;
	logic                       tick;
	logic                       trig;
	logic                       match;
	logic                       act_r;
	logic                       act_nxt;
	logic                       w0_r;
	logic                       w0_nxt;
	logic                       w1_r;
	logic                       w1_nxt;
	logic                       tick_r;
	logic                       tick_nxt;
	logic                       clr_r;
	logic                       clr_nxt;

	tmc_in_sync u_sync (
		.ref_clk_i   (ref_clk_i),
		.nrst_i      (nrst_i),
		.ext_event_i (ext_event_i),
		.ext_trig_i  (ext_trig_i),
		.lk          (lk)
	);

	tmc_out_stage u_out (
		.ref_clk_i        (ref_clk_i),
		.nrst_i           (nrst_i),
		.out_cfg_i        (out_r[3:0]),
		.lk               (lk),
		.timer_out_pin0_o (timer_out_pin0_o),
		.timer_out_pin1_o (timer_out_pin1_o)
	);

	// Register writes.
	assign mode_wv = apply_write(mode_r, wdata_i, bit_op_i, bit_sel_i);
	// The trigger bit is never stored, so writing zero there cannot start anything.
	assign soft_trig = wr_i && (addr_i == tmc_pkg::ADDR_MODE)
		&& mode_wv[tmc_pkg::MODE_TRIG_BIT];

	always_comb begin
		mode_nxt = mode_r;
		out_nxt  = out_r;
		run_nxt  = run_r;
		for (int i = 0; i < 4; i++) begin
			cmp_nxt[i] = cmp_r[i];
		end
		if (wr_i) begin
			if (addr_i == tmc_pkg::ADDR_MODE) begin
				mode_nxt = mode_wv & tmc_pkg::MODE_WMASK;
			end else if (addr_i == tmc_pkg::ADDR_OUT) begin
				out_nxt = apply_write(out_r, wdata_i, bit_op_i, bit_sel_i)
					& tmc_pkg::OUT_WMASK;
			end else if (addr_i == tmc_pkg::ADDR_RUN) begin
				run_nxt = apply_write(run_r, wdata_i, bit_op_i, bit_sel_i)
					& tmc_pkg::RUN_WMASK;
			end else if (addr_i >= tmc_pkg::ADDR_PER_LO && addr_i <= tmc_pkg::ADDR_DUTY_HI) begin
				cmp_nxt[2'(addr_i - tmc_pkg::ADDR_PER_LO)] =
					apply_write(cmp_r[2'(addr_i - tmc_pkg::ADDR_PER_LO)],
						wdata_i, bit_op_i, bit_sel_i);
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode_r <= tmc_pkg::RESET_BYTE;
			out_r  <= tmc_pkg::RESET_BYTE;
			run_r  <= tmc_pkg::RESET_BYTE;
			for (int i = 0; i < 4; i++) begin
				cmp_r[i] <= tmc_pkg::RESET_BYTE;
			end
		end else begin
			mode_r <= mode_nxt;
			out_r  <= out_nxt;
			run_r  <= run_nxt;
			for (int i = 0; i < 4; i++) begin
				cmp_r[i] <= cmp_nxt[i];
			end
		end
	end

	// Read path: data appear only in the cycle after the strobe.
	always_comb begin
		rd_byte = tmc_pkg::ZERO_BYTE;
		if (addr_i == tmc_pkg::ADDR_MODE) begin
			rd_byte = mode_r;
		end else if (addr_i == tmc_pkg::ADDR_OUT) begin
			rd_byte = out_r;
		end else if (addr_i == tmc_pkg::ADDR_RUN) begin
			rd_byte = run_r;
		end else if (addr_i >= tmc_pkg::ADDR_PER_LO && addr_i <= tmc_pkg::ADDR_DUTY_HI) begin
			rd_byte = cmp_r[2'(addr_i - tmc_pkg::ADDR_PER_LO)];
		end else if (addr_i == tmc_pkg::ADDR_CNT_LO) begin
			rd_byte = cnt_r[7:0];
		end else if (addr_i == tmc_pkg::ADDR_CNT_HI) begin
			rd_byte = cnt_r[15:8];
		end else if (addr_i == tmc_pkg::ADDR_CAP_LO) begin
			rd_byte = cap_r[7:0];
		end else if (addr_i == tmc_pkg::ADDR_CAP_HI) begin
			rd_byte = cap_r[15:8];
		end
		rdata_nxt = tmc_pkg::ZERO_BYTE;
		if (rd_i) begin
			if (bit_op_i) begin
				rdata_nxt = {7'h00, rd_byte[bit_sel_i]};
			end else begin
				rdata_nxt = rd_byte;
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_r <= tmc_pkg::ZERO_BYTE;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// Count source selection.
	assign mode     = tmc_pkg::tmc_mode_e'(mode_r[2:0]);
	assign period   = {cmp_r[1], cmp_r[0]};
	assign duty     = {cmp_r[3], cmp_r[2]};
	assign running  = run_r[tmc_pkg::RUN_BIT];
	assign slave    = mode_r[tmc_pkg::MODE_SLAVE_BIT];
	assign pre_mask = ~(tmc_pkg::PRE_ONES << run_r[2:0]);
	assign pre_tick = (div_r & pre_mask) == pre_mask;
	assign ext_src  = (mode == tmc_pkg::MD_EVENT) || mode_r[tmc_pkg::MODE_EXT_BIT];
	// A slave takes its count enable from the master so both stay in step.
	assign tick     = slave ? master_tick_i : (ext_src ? lk.ev_edge : pre_tick);
	assign trig     = lk.trig_rise || soft_trig;
	assign match    = cnt_r == period;

	// Mode sequencer. Mode and source are assumed stable while running; a change
	// under way only takes proper effect after the run bit is cycled.
	always_comb begin
		cnt_nxt  = cnt_r;
		cap_nxt  = cap_r;
		act_nxt  = act_r;
		w0_nxt   = w0_r;
		w1_nxt   = w1_r;
		clr_nxt  = 1'b0;
		tick_nxt = 1'b0;
		div_nxt  = tmc_pkg::PRE_ZERO;
		if (running) begin
			div_nxt  = div_r + tmc_pkg::PRE_ONE;
			tick_nxt = tick && (mode != tmc_pkg::MD_PROHIBITED);
			case (mode)
				tmc_pkg::MD_TRIG_PULSE, tmc_pkg::MD_ONE_SHOT: begin
					// A one-shot ignores triggers until its pulse has ended.
					if (trig && !(mode == tmc_pkg::MD_ONE_SHOT && act_r)) begin
						cnt_nxt = tmc_pkg::CNT_ZERO;
						act_nxt = 1'b1;
						clr_nxt = 1'b1;
					end else if (act_r && tick) begin
						if (match) begin
							cnt_nxt = tmc_pkg::CNT_ZERO;
							act_nxt = 1'b0;
							clr_nxt = 1'b1;
						end else begin
							cnt_nxt = cnt_r + tmc_pkg::CNT_ONE;
						end
					end
				end
				tmc_pkg::MD_WIDTH: begin
					if (lk.trig_rise) begin
						cnt_nxt = tmc_pkg::CNT_ZERO;
						clr_nxt = 1'b1;
					end else if (lk.trig_fall) begin
						cap_nxt = cnt_r;
					end else if (tick && lk.trig_level && cnt_r != tmc_pkg::CNT_MAX) begin
						cnt_nxt = cnt_r + tmc_pkg::CNT_ONE;
					end
				end
				tmc_pkg::MD_FREE_RUN: begin
					if (tick) begin
						cnt_nxt = cnt_r + tmc_pkg::CNT_ONE;
						if (match) begin
							w0_nxt = ~w0_r;
						end
					end
				end
				tmc_pkg::MD_PROHIBITED: begin
					cnt_nxt = cnt_r;
				end
				default: begin
					if (tick) begin
						if (match) begin
							cnt_nxt = tmc_pkg::CNT_ZERO;
							clr_nxt = 1'b1;
							w0_nxt  = ~w0_r;
						end else begin
							cnt_nxt = cnt_r + tmc_pkg::CNT_ONE;
						end
					end
				end
			endcase
			if (slave && master_clear_i) begin
				cnt_nxt = tmc_pkg::CNT_ZERO;
				clr_nxt = 1'b1;
			end
			if (mode == tmc_pkg::MD_PWM) begin
				w1_nxt = cnt_nxt < duty;
			end else if (mode == tmc_pkg::MD_TRIG_PULSE || mode == tmc_pkg::MD_ONE_SHOT) begin
				w1_nxt = act_nxt && (cnt_nxt >= duty);
			end else begin
				w1_nxt = w0_nxt;
			end
		end else begin
			// Stopping the timer returns the counter and waves to their idle state.
			cnt_nxt = tmc_pkg::CNT_ZERO;
			act_nxt = 1'b0;
			w0_nxt  = 1'b0;
			w1_nxt  = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_r  <= tmc_pkg::CNT_ZERO;
			cap_r  <= tmc_pkg::CNT_ZERO;
			div_r  <= tmc_pkg::PRE_ZERO;
			act_r  <= 1'b0;
			w0_r   <= 1'b0;
			w1_r   <= 1'b0;
			tick_r <= 1'b0;
			clr_r  <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			cap_r  <= cap_nxt;
			div_r  <= div_nxt;
			act_r  <= act_nxt;
			w0_r   <= w0_nxt;
			w1_r   <= w1_nxt;
			tick_r <= tick_nxt;
			clr_r  <= clr_nxt;
		end
	end

	assign lk.wave0      = w0_r;
	assign lk.wave1      = w1_r;
	assign rdata_o       = rdata_r;
	assign count_tick_o  = tick_r;
	assign count_clear_o = clr_r;

endmodule

`default_nettype wire

// ==== test/tmc_chk.sv ====
`default_nettype none
module tmc_chk (
	input wire logic       ref_clk_i,
	input wire logic       nrst_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic       bit_op_i,
	input wire logic [2:0] bit_sel_i,
	input wire logic [7:0] rdata_o,
	input wire logic       ext_event_i,
	input wire logic       master_tick_i,
	input wire logic       count_tick_o,
	input wire logic       count_clear_o,
	input wire logic       timer_out_pin0_o,
	input wire logic       timer_out_pin1_o
);
	// Shadow copies of mode and run so the tick checks know which source is live.
	logic [7:0] mode_r, mode_nxt, run_r, run_nxt;
	logic       wo, ro;
	assign wo = wr_i && !bit_op_i && addr_i == tmc_pkg::ADDR_OUT;
	assign ro = rd_i && !bit_op_i && addr_i == tmc_pkg::ADDR_OUT;
	always_comb begin
		mode_nxt = mode_r;
		run_nxt = run_r;
		if (wr_i && addr_i == tmc_pkg::ADDR_MODE && bit_op_i) mode_nxt[bit_sel_i] = wdata_i[0];
		if (wr_i && addr_i == tmc_pkg::ADDR_MODE && !bit_op_i) mode_nxt = wdata_i;
		if (wr_i && addr_i == tmc_pkg::ADDR_RUN && bit_op_i) run_nxt[bit_sel_i] = wdata_i[0];
		if (wr_i && addr_i == tmc_pkg::ADDR_RUN && !bit_op_i) run_nxt = wdata_i;
	end
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mode_r <= 8'h00;
			run_r <= 8'h00;
		end else begin
			mode_r <= mode_nxt;
			run_r <= run_nxt;
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	property p_rd_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_out_rd; ro |=> rdata_o[7:4] == 4'h0; endproperty
	a_out_rd: assert property (p_out_rd) else $error("output reg upper bits set");
	property p_mode_rd;
		rd_i && !bit_op_i && addr_i == tmc_pkg::ADDR_MODE |=> rdata_o[4:3] == 2'h0;
	endproperty
	a_mode_rd: assert property (p_mode_rd) else $error("mode reg zero bits set");
	property p_bit_rd; rd_i && bit_op_i |=> rdata_o[7:1] == 7'h00; endproperty
	a_bit_rd: assert property (p_bit_rd) else $error("bit read wide");
	property p_wr_rd;
		wo ##1 !wr_i ##1 (ro && !wr_i) |=> rdata_o == ($past(wdata_i, 3) & tmc_pkg::OUT_WMASK);
	endproperty
	a_wr_rd: assert property (p_wr_rd) else $error("output reg readback");
	property p_pin0_static;
		wo && !wdata_i[0] ##1 !(wr_i && addr_i == tmc_pkg::ADDR_OUT)
			|=> timer_out_pin0_o == $past(wdata_i[1], 2);
	endproperty
	a_pin0_static: assert property (p_pin0_static) else $error("pin0 level");
	property p_pin1_static;
		wo && !wdata_i[2] ##1 !(wr_i && addr_i == tmc_pkg::ADDR_OUT)
			|=> timer_out_pin1_o == $past(wdata_i[3], 2);
	endproperty
	a_pin1_static: assert property (p_pin1_static) else $error("pin1 level");
	property p_stop_idle; (!run_r[7] && !mode_r[7]) [*3] |-> !count_tick_o; endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("tick while stopped");
	property p_int_tick;
		(run_r == 8'h80 && (mode_r & 8'ha7) == 8'h00) [*3] |-> count_tick_o;
	endproperty
	a_int_tick: assert property (p_int_tick) else $error("internal tick missing");
	property p_slave; (run_r[7] && mode_r[7]) [*2] |-> count_tick_o == $past(master_tick_i);
	endproperty
	a_slave: assert property (p_slave) else $error("slave tick mismatch");
	property p_ext_quiet;
		(run_r[7] && !mode_r[7] && (mode_r[5] || mode_r[2:0] == 3'h1) && $stable(ext_event_i))
			[*6] |-> !count_tick_o;
	endproperty
	a_ext_quiet: assert property (p_ext_quiet) else $error("tick without event");
	c_slave: cover property (run_r[7] && mode_r[7] && count_tick_o);
	c_trig: cover property (wr_i && addr_i == tmc_pkg::ADDR_MODE && wdata_i[6] ##[1:4] count_clear_o);
	c_bit: cover property (rd_i && bit_op_i);
endmodule
bind tmc_timer_channel tmc_chk tmc_chk_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .bit_op_i(bit_op_i),
	.bit_sel_i(bit_sel_i), .rdata_o(rdata_o), .ext_event_i(ext_event_i),
	.master_tick_i(master_tick_i), .count_tick_o(count_tick_o), .count_clear_o(count_clear_o),
	.timer_out_pin0_o(timer_out_pin0_o), .timer_out_pin1_o(timer_out_pin1_o));
`default_nettype wire

// ==== test/tmc_timer_channel_tb.sv ====
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tmc_timer_channel_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       ref_clk_i = 0, nrst_i = 0, wr_i = 0, rd_i = 0, bit_op_i = 0;
	logic       ext_event_i = 0, ext_trig_i = 0, master_tick_i = 0, master_clear_i = 0;
	logic [3:0] addr_i = 4'h0;
	logic [7:0] wdata_i = 8'h00;
	logic [2:0] bit_sel_i = 3'h0;
	logic [7:0] rdata_o;
	logic       count_tick_o, count_clear_o, timer_out_pin0_o, timer_out_pin1_o, pin_q;
	int         fail_count = 0, n_compared = 0, n_tick = 0, n_clr = 0, n_tog = 0, t0, c0, g0;
	int         n_hi = 0, h0;
	// Rows: address, written byte, expected readback.
	logic [19:0] rows [12] = '{20'h0_00_00, 20'h0_01_01, 20'h0_02_02, 20'h0_03_03,
		20'h0_04_04, 20'h0_05_05, 20'h0_06_06, 20'h0_07_07, 20'h0_ff_a7, 20'h1_ff_0f,
		20'h1_0a_0a, 20'hf_ff_00};
	tmc_timer_channel tmc_timer_channel_i (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .bit_op_i(bit_op_i),
		.bit_sel_i(bit_sel_i), .rdata_o(rdata_o), .ext_event_i(ext_event_i),
		.ext_trig_i(ext_trig_i), .master_tick_i(master_tick_i), .master_clear_i(master_clear_i),
		.count_tick_o(count_tick_o), .count_clear_o(count_clear_o),
		.timer_out_pin0_o(timer_out_pin0_o), .timer_out_pin1_o(timer_out_pin1_o));
	initial forever #5 ref_clk_i = ~ref_clk_i;
	// Tallies run on the falling edge so they never race the rising-edge snapshots.
	always @(negedge ref_clk_i) begin
		n_tick += (count_tick_o === 1'b1);
		n_clr += (count_clear_o === 1'b1);
		n_tog += (timer_out_pin0_o !== pin_q);
		n_hi += (timer_out_pin1_o === 1'b1);
		pin_q = timer_out_pin0_o;
	end
	task stop_test;
		if (fail_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d, input logic b = 0, input logic [2:0] s = 0);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		bit_op_i <= b;
		bit_sel_i <= s;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e, input logic b = 0, input logic [2:0] s = 0);
		@(posedge ref_clk_i);
		addr_i <= a;
		bit_op_i <= b;
		bit_sel_i <= s;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 `CHK(rdata_o, e)
	endtask
	task snap;
		t0 = n_tick;
		c0 = n_clr;
		g0 = n_tog;
		h0 = n_hi;
	endtask
	task wait_n(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	// cfg only rewrites mode with the run bit clear; changing it live is undefined.
	task cfg(input logic [7:0] m);
		wr(tmc_pkg::ADDR_RUN, 8'h00);
		wr(tmc_pkg::ADDR_MODE, m);
		wr(tmc_pkg::ADDR_RUN, 8'h80);
		wait_n(5);
		snap;
	endtask
	// The pulse is held long enough to pass the two-flop synchroniser.
	task pulse_ev;
		snap;
		@(posedge ref_clk_i);
		ext_event_i <= 1'b1;
		wait_n(5);
		ext_event_i <= 1'b0;
		wait_n(10);
	endtask
	initial begin
		#50000;
		fail_count++;
		stop_test;
	end
	initial begin
		wait_n(2);
		nrst_i <= 1'b1;
		rd(tmc_pkg::ADDR_MODE, 8'h00);
		rd(tmc_pkg::ADDR_OUT, 8'h00);
		`CHK({timer_out_pin1_o, timer_out_pin0_o}, 2'b00)
		foreach (rows[k]) begin
			wr(rows[k][19:16], rows[k][15:8]);
			rd(rows[k][19:16], rows[k][7:0]);
		end
		wr(tmc_pkg::ADDR_OUT, 8'h00);
		wr(tmc_pkg::ADDR_OUT, 8'h01, 1'b1, 3'h2);
		rd(tmc_pkg::ADDR_OUT, 8'h04);
		rd(tmc_pkg::ADDR_OUT, 8'h01, 1'b1, 3'h2);
		rd(tmc_pkg::ADDR_OUT, 8'h00, 1'b1, 3'h3);
		for (int i = 0; i < 16; i++) begin
			wr(tmc_pkg::ADDR_OUT, 8'(i));
			wait_n(2);
			#1 `CHK(timer_out_pin0_o, i[1])
			`CHK(timer_out_pin1_o, i[3])
		end
		wr(tmc_pkg::ADDR_PER_LO, 8'h03);
		wr(tmc_pkg::ADDR_OUT, 8'h01);
		cfg(8'h00);
		wait_n(20);
		`CHK(n_tick - t0, 20)
		`CHK(n_tog - g0 > 1, 1'b1)
		wr(tmc_pkg::ADDR_RUN, 8'h00);
		wr(tmc_pkg::ADDR_RUN, 8'h82);
		wait_n(4);
		snap;
		wait_n(40);
		`CHK(n_tick - t0, 10)
		cfg(8'h20);
		wait_n(20);
		`CHK(n_tick - t0, 0)
		pulse_ev;
		`CHK(n_tick - t0, 1)
		cfg(8'h01);
		wait_n(20);
		`CHK(n_tick - t0, 0)
		pulse_ev;
		`CHK(n_tick - t0, 1)
		cfg(8'h80);
		@(posedge ref_clk_i);
		master_tick_i <= 1'b1;
		wait_n(8);
		master_tick_i <= 1'b0;
		wait_n(4);
		`CHK(n_tick - t0, 8)
		snap;
		@(posedge ref_clk_i);
		master_clear_i <= 1'b1;
		@(posedge ref_clk_i);
		master_clear_i <= 1'b0;
		wait_n(4);
		`CHK(n_clr - c0, 1)
		wr(tmc_pkg::ADDR_PER_LO, 8'h0a);
		cfg(8'h02);
		wr(tmc_pkg::ADDR_MODE, 8'h02);
		wait_n(8);
		`CHK(n_clr - c0, 0)
		snap;
		wr(tmc_pkg::ADDR_MODE, 8'h42);
		wait_n(4);
		`CHK(n_clr - c0 > 0, 1'b1)
		wait_n(20);
		snap;
		@(posedge ref_clk_i);
		ext_trig_i <= 1'b1;
		wait_n(5);
		ext_trig_i <= 1'b0;
		`CHK(n_clr - c0 > 0, 1'b1)
		cfg(8'h06);
		@(posedge ref_clk_i);
		ext_trig_i <= 1'b1;
		wait_n(10);
		ext_trig_i <= 1'b0;
		wait_n(5);
		rd(tmc_pkg::ADDR_CAP_LO, 8'h09);
		rd(tmc_pkg::ADDR_CAP_HI, 8'h00);
		// Output bits are only rewritten with the timer stopped.
		wr(tmc_pkg::ADDR_RUN, 8'h00);
		wr(tmc_pkg::ADDR_DUTY_LO, 8'h04);
		wr(tmc_pkg::ADDR_OUT, 8'h04);
		cfg(8'h04);
		wait_n(22);
		`CHK(n_hi - h0, 8)
		wr(tmc_pkg::ADDR_RUN, 8'h00);
		wr(tmc_pkg::ADDR_OUT, 8'h0c);
		cfg(8'h04);
		wait_n(22);
		`CHK(n_hi - h0, 14)
		@(posedge ref_clk_i);
		nrst_i <= 1'b0;
		wait_n(2);
		nrst_i <= 1'b1;
		rd(tmc_pkg::ADDR_MODE, 8'h00);
		rd(tmc_pkg::ADDR_OUT, 8'h00);
		stop_test;
	end
endmodule
`default_nettype wire
